// file: hw/cml_pkg.sv
// Constants and field layout for the macrocell logic block slice
package cml_pkg;
  // ---------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------
  localparam int NUM_MC = 4;
  localparam int NUM_PT = 5;
  localparam int NUM_DED = 4;
  localparam int NUM_GCK = 3;
  localparam int SM_OUT = 40;
  localparam int GBUS_W = 68;
  localparam int EXT_W = 56;
  localparam int PT_IN_W = SM_OUT + NUM_MC;
  localparam int SM_SEL_W = 7;
  localparam int SYNC_W = 1 + EXT_W + NUM_MC + NUM_DED;
  // Global bus layout
  localparam int GB_DED_LO = 0;
  localparam int GB_IO_LO = 4;
  localparam int GB_FB_LO = 8;
  localparam int GB_EXT_LO = 12;
  // ---------------------------------------------------------------
  // APB map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] SM_BASE = 12'h000;
  localparam logic [11:0] SM_WORDS = 12'h028;
  localparam logic [11:0] PT_BASE = 12'h100;
  localparam logic [11:0] PT_WORDS = 12'h050;
  localparam logic [11:0] MC_BASE = 12'h300;
  localparam logic [11:0] MC_WORDS = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h380;
  localparam logic [31:0] MC_CFG_RST = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Product term roles
  // ---------------------------------------------------------------
  localparam int PT_XOR = 0;
  localparam int PT_CLK = 1;
  localparam int PT_CE = 2;
  localparam int PT_AR = 3;
  localparam int PT_AP = 4;
  // ---------------------------------------------------------------
  // Macrocell config word fields
  // ---------------------------------------------------------------
  localparam int OR_MASK_LO = 0;
  localparam int CASC_EN_BIT = 5;
  localparam int XOR_SEL_LO = 6;
  localparam int D_SEL_LO = 8;
  localparam int MODE_LO = 10;
  localparam int CLK_SEL_LO = 13;
  localparam int CE_EN_BIT = 15;
  localparam int AR_SEL_LO = 16;
  localparam int AP_EN_BIT = 18;
  localparam int OUT_REG_BIT = 19;
  localparam int FB_REG_BIT = 20;
  localparam int OE_SEL_LO = 21;
  localparam int OE_IDX_LO = 24;
  localparam int IO_MODE_LO = 26;
  localparam int FOLD_PT_LO = 28;
  localparam int GCLR_BIT = 31;
  // Dedicated pin roles
  localparam int GCLR_PIN_A = 3;
  localparam int GCLR_PIN_B = 2;
  localparam int OE_PIN_BASE = 2;
  // Field encodings
  localparam logic [1:0] XOR_PT = 2'h0;
  localparam logic [1:0] XOR_HIGH = 2'h1;
  localparam logic [1:0] D_XOR = 2'h0;
  localparam logic [1:0] D_PT = 2'h1;
  localparam logic [2:0] FF_D = 3'h0;
  localparam logic [2:0] FF_T = 3'h1;
  localparam logic [2:0] FF_JK = 3'h2;
  localparam logic [2:0] FF_SR = 3'h3;
  localparam logic [2:0] FF_LATCH = 3'h4;
  localparam logic [1:0] CLK_PT = 2'h3;
  localparam logic [1:0] AR_GCLR = 2'h1;
  localparam logic [1:0] AR_PT = 2'h2;
  localparam logic [1:0] AR_BOTH = 2'h3;
  localparam logic [2:0] OE_PIN_T = 3'h0;
  localparam logic [2:0] OE_PIN_C = 3'h1;
  localparam logic [2:0] OE_IO = 3'h2;
  localparam logic [2:0] OE_MC = 3'h3;
  localparam logic [1:0] IO_OUT = 2'h1;
  localparam logic [1:0] IO_BIDIR = 2'h2;
endpackage

// file: hw/cml_logic_block.sv
// Macrocell logic block slice with APB configuration port
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RULE_01] Five product terms per macrocell, fed by global and regional bus.
// [RULE_02] Allocator can route all five terms into the OR gate.
// [RULE_03] Cascade input extends a sum term to forty terms along a chain.
// [RULE_04] XOR takes OR sum and a product term, high or low.
// [RULE_05] Constant XOR input sets polarity; XOR also emulates T and JK.
// [RULE_06] Flop data from XOR output, a product term, or the pin.
// [RULE_07] Storage runs as D, T, JK, SR flop or flow-through latch.
// [RULE_08] Latch passes data while clock high, holds while low.
// [RULE_09] Flop clock is one of three global clocks or a product term.
// [RULE_10] Flop modes change state only on rising edge of selected clock.
// [RULE_11] With a global clock, a low product-term enable ignores edges.
// [RULE_12] Reset is global clear, product term, their OR, or off.
// [RULE_13] Preset is a product term or off.
// [RULE_14] Each macrocell output is registered or combinatorial.
// [RULE_15] Buried feedback picks registered or combinatorial independently of output.
// [RULE_16] Output enable from either OE pin true/complement, an I/O, or macrocell.
// [RULE_17] I/O is input, output or bidirectional; input keeps internal logic usable.
// [RULE_18] Global bus carries all pins plus all buried feedback.
// [RULE_19] Switch matrix selects up to forty global bus signals.
// [RULE_20] Each macrocell folds back an inverted product term to the region.
// [RULE_21] Four foldback terms plus local terms give nine-term sums.
// [RULE_22] Each macrocell individually picks dedicated pins for clock, clear, enable.
// [RULE_23] Reset beats preset when both are active.
module cml_logic_block (
  // Clock, reset, freeze
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [cml_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Device pins
  input wire logic [cml_pkg::NUM_DED-1:0] i_dedicated_pins,
  input wire logic [cml_pkg::NUM_MC-1:0] i_io_pin_in,
  output logic [cml_pkg::NUM_MC-1:0] o_io_pin_out,
  output logic [cml_pkg::NUM_MC-1:0] o_io_pin_oe_n,
  // Global bus and cascade neighbours
  input wire logic [cml_pkg::EXT_W-1:0] i_global_bus_ext,
  output logic [cml_pkg::NUM_MC-1:0] o_buried_feedback,
  input wire logic i_cascade_sum_input,
  output logic o_cascade_sum_output
);
  import cml_pkg::*;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // AND of selected true and complement literals; empty term is high
  function automatic logic pt_eval(input logic [PT_IN_W-1:0] t,
                                   input logic [PT_IN_W-1:0] c,
                                   input logic [PT_IN_W-1:0] v);
    return (&(~t | v)) & (&(~c | ~v));
  endfunction

  // Address inside a block of words, word aligned
  function automatic logic in_blk(input logic [11:0] a,
                                  input logic [11:0] base,
                                  input logic [11:0] words);
    logic [11:0] d;
    d = a - base;
    return (a >= base) && (d < (words << 2)) && (a[1:0] == 2'h0);
  endfunction

  // Word offset inside a block
  function automatic logic [9:0] woff(input logic [11:0] a,
                                      input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[11:2];
  endfunction

  // Next state of a clocked storage element
  function automatic logic ff_next(input logic [2:0] mode,
                                   input logic q,
                                   input logic d,
                                   input logic k);
    case (mode)
      FF_T: return q ^ d;
      FF_JK: return (d & ~q) | (~k & q);
      FF_SR: return d | (~k & q);
      default: return d;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [NUM_DED-1:0] ded_s;
  logic [NUM_MC-1:0] io_s;
  logic [EXT_W-1:0] ext_s;
  logic casc_s;

  // Two flops on every pin; only sync_b is read by logic
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else if (i_ce)
    begin
      sync_a <= {i_cascade_sum_input, i_global_bus_ext, i_io_pin_in, i_dedicated_pins};
      sync_b <= sync_a;
    end
  end

  assign ded_s = sync_b[NUM_DED-1:0];
  assign io_s = sync_b[NUM_DED +: NUM_MC];
  assign ext_s = sync_b[NUM_DED+NUM_MC +: EXT_W];
  assign casc_s = sync_b[SYNC_W-1];

  // ---------------------------------------------------------------
  // Configuration storage
  // ---------------------------------------------------------------
  logic [SM_SEL_W-1:0] sm_sel [SM_OUT];
  logic [PT_IN_W-1:0] pt_true [NUM_MC*NUM_PT];
  logic [PT_IN_W-1:0] pt_comp [NUM_MC*NUM_PT];
  logic [31:0] mc_cfg [NUM_MC];
  logic wr_en;
  logic hit_sm;
  logic hit_pt;
  logic hit_mc;
  logic hit_st;
  logic [9:0] off_sm;
  logic [9:0] off_pt;
  logic [9:0] off_mc;

  assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
  assign hit_sm = in_blk(i_paddr, SM_BASE, SM_WORDS);
  assign hit_pt = in_blk(i_paddr, PT_BASE, PT_WORDS);
  assign hit_mc = in_blk(i_paddr, MC_BASE, MC_WORDS);
  assign hit_st = (i_paddr == STAT_ADDR);
  assign off_sm = woff(i_paddr, SM_BASE);
  assign off_pt = woff(i_paddr, PT_BASE);
  assign off_mc = woff(i_paddr, MC_BASE);

  // Switch matrix selects, one global bus index per slot
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < SM_OUT; k++)
        sm_sel[k] <= '0;
    end
    else if (i_ce && wr_en && hit_sm)
    begin
      sm_sel[off_sm[5:0]] <= i_pwdata[SM_SEL_W-1:0];  // [RULE_19]
    end
  end

  // Product term masks: four words per term, true then complement
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < NUM_MC*NUM_PT; k++)
      begin
        pt_true[k] <= '0;
        pt_comp[k] <= '0;
      end
    end
    else if (i_ce && wr_en && hit_pt)
    begin
      case (off_pt[1:0])
        2'h0: pt_true[off_pt[6:2]][31:0] <= i_pwdata;
        2'h1: pt_true[off_pt[6:2]][PT_IN_W-1:32] <= i_pwdata[PT_IN_W-33:0];
        2'h2: pt_comp[off_pt[6:2]][31:0] <= i_pwdata;
        default: pt_comp[off_pt[6:2]][PT_IN_W-1:32] <= i_pwdata[PT_IN_W-33:0];
      endcase
    end
  end

  // Macrocell configuration words
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < NUM_MC; k++)
        mc_cfg[k] <= MC_CFG_RST;
    end
    else if (i_ce && wr_en && hit_mc)
    begin
      mc_cfg[off_mc[1:0]] <= i_pwdata;
    end
  end

  // ---------------------------------------------------------------
  // Global bus, switch matrix, product terms
  // ---------------------------------------------------------------
  logic [GBUS_W-1:0] gbus;
  logic [SM_OUT-1:0] sm;
  logic [NUM_MC-1:0] fold_q;
  logic [PT_IN_W-1:0] pt_in;
  logic [NUM_PT-1:0] ptm [NUM_MC];

  // Feedback enters the bus registered so no loop closes through it
  assign gbus = {ext_s, o_buried_feedback, io_s, ded_s};  // [RULE_18]
  assign pt_in = {fold_q, sm};  // [RULE_21]

  // Out-of-range selects read low
  always_comb
  begin
    for (int k = 0; k < SM_OUT; k++)
      sm[k] = (int'(sm_sel[k]) < GBUS_W) ? gbus[sm_sel[k]] : 1'b0;  // [RULE_19]
  end

  // Every term sees all switch outputs and all foldback terms
  always_comb
  begin
    for (int m = 0; m < NUM_MC; m++)
      for (int p = 0; p < NUM_PT; p++)
        ptm[m][p] = pt_eval(pt_true[m*NUM_PT+p], pt_comp[m*NUM_PT+p], pt_in);  // [RULE_01]
  end

  // ---------------------------------------------------------------
  // Sum, XOR, data, clock and control selection
  // ---------------------------------------------------------------
  logic [NUM_MC-1:0] or_sum;
  logic [NUM_MC-1:0] xor_out;
  logic [NUM_MC-1:0] d_in;
  logic [NUM_MC-1:0] clk_lvl;
  logic [NUM_MC-1:0] ce_ok;
  logic [NUM_MC-1:0] ar;
  logic [NUM_MC-1:0] ap;
  logic [NUM_MC-1:0] clk_prev;
  logic [NUM_MC-1:0] q;
  logic casc_end;

  always_comb
  begin
    logic casc;
    logic xb;
    logic gclr;
    logic [31:0] c;
    xb = 1'b0;
    gclr = 1'b0;
    c = '0;
    casc = casc_s;
    for (int m = 0; m < NUM_MC; m++)
    begin
      c = mc_cfg[m];
      // Allocator routes any subset of the five terms; chain adds upstream sum
      or_sum[m] = (|(ptm[m] & c[OR_MASK_LO +: NUM_PT])) | (c[CASC_EN_BIT] & casc);  // [RULE_02] [RULE_03]
      casc = or_sum[m];
      case (c[XOR_SEL_LO +: 2])
        XOR_PT: xb = ptm[m][PT_XOR];
        XOR_HIGH: xb = 1'b1;
        default: xb = 1'b0;
      endcase
      xor_out[m] = or_sum[m] ^ xb;  // [RULE_04] [RULE_05]
      case (c[D_SEL_LO +: 2])
        D_XOR: d_in[m] = xor_out[m];
        D_PT: d_in[m] = ptm[m][PT_XOR];
        default: d_in[m] = io_s[m];
      endcase  // [RULE_06]
      if (c[CLK_SEL_LO +: 2] == CLK_PT)
        clk_lvl[m] = ptm[m][PT_CLK];
      else
        clk_lvl[m] = ded_s[c[CLK_SEL_LO +: 2]];  // [RULE_09] [RULE_22]
      // Enable only applies with a global clock
      ce_ok[m] = ~c[CE_EN_BIT] | (c[CLK_SEL_LO +: 2] == CLK_PT) | ptm[m][PT_CE];  // [RULE_11]
      gclr = c[GCLR_BIT] ? ded_s[GCLR_PIN_B] : ded_s[GCLR_PIN_A];  // [RULE_22]
      case (c[AR_SEL_LO +: 2])
        AR_GCLR: ar[m] = gclr;
        AR_PT: ar[m] = ptm[m][PT_AR];
        AR_BOTH: ar[m] = gclr | ptm[m][PT_AR];
        default: ar[m] = 1'b0;
      endcase  // [RULE_12]
      ap[m] = c[AP_EN_BIT] & ptm[m][PT_AP];  // [RULE_13]
    end
    casc_end = casc;
  end

  // ---------------------------------------------------------------
  // Storage elements
  // ---------------------------------------------------------------
  // Pin-derived clocks are sampled, so edges closer than one cycle can merge
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
      clk_prev <= '0;
    end
    else if (i_ce)
    begin
      clk_prev <= clk_lvl;
      for (int m = 0; m < NUM_MC; m++)
      begin
        if (ar[m])
          q[m] <= 1'b0;  // [RULE_23]
        else if (ap[m])
          q[m] <= 1'b1;
        else if (mc_cfg[m][MODE_LO +: 3] == FF_LATCH)
        begin
          if (clk_lvl[m] && ce_ok[m])
            q[m] <= d_in[m];  // [RULE_08]
        end
        else if (clk_lvl[m] && !clk_prev[m] && ce_ok[m])
          q[m] <= ff_next(mc_cfg[m][MODE_LO +: 3], q[m], d_in[m], ptm[m][PT_CE]);  // [RULE_07] [RULE_10]
      end
    end
  end

  // ---------------------------------------------------------------
  // Output, feedback, foldback and enable
  // ---------------------------------------------------------------
  logic [NUM_MC-1:0] out_sel;
  logic [NUM_MC-1:0] fb_sel;
  logic [NUM_MC-1:0] fold;
  logic [NUM_MC-1:0] drive;

  always_comb
  begin
    logic [31:0] c;
    logic oe;
    logic [1:0] ix;
    c = '0;
    oe = 1'b0;
    ix = '0;
    for (int m = 0; m < NUM_MC; m++)
    begin
      c = mc_cfg[m];
      ix = c[OE_IDX_LO +: 2];
      out_sel[m] = c[OUT_REG_BIT] ? q[m] : xor_out[m];  // [RULE_14]
      fb_sel[m] = c[FB_REG_BIT] ? q[m] : xor_out[m];  // [RULE_15]
      fold[m] = (int'(c[FOLD_PT_LO +: 3]) < NUM_PT) ? ~ptm[m][c[FOLD_PT_LO +: 3]] : 1'b0;  // [RULE_20]
      case (c[OE_SEL_LO +: 3])
        OE_PIN_T: oe = ded_s[OE_PIN_BASE + int'(ix[0])];
        OE_PIN_C: oe = ~ded_s[OE_PIN_BASE + int'(ix[0])];
        OE_IO: oe = io_s[ix];
        OE_MC: oe = o_io_pin_out[ix];
        default: oe = 1'b1;
      endcase  // [RULE_16] [RULE_22]
      // Input mode only gates the driver; internal paths keep running
      case (c[IO_MODE_LO +: 2])
        IO_OUT: drive[m] = 1'b1;
        IO_BIDIR: drive[m] = oe;
        default: drive[m] = 1'b0;
      endcase  // [RULE_17]
    end
  end

  // Registered pin, feedback, foldback and cascade outputs
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_io_pin_out <= '0;
      o_io_pin_oe_n <= '1;
      o_buried_feedback <= '0;
      fold_q <= '0;
      o_cascade_sum_output <= 1'b0;
    end
    else if (i_ce)
    begin
      o_io_pin_out <= out_sel;
      o_io_pin_oe_n <= ~drive;
      o_buried_feedback <= fb_sel;
      fold_q <= fold;  // [RULE_20]
      o_cascade_sum_output <= casc_end;  // [RULE_03]
    end
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  logic [31:0] next_prdata;

  // Read word chosen at setup; status is a snapshot of that cycle
  always_comb
  begin
    next_prdata = '0;
    if (hit_sm)
      next_prdata[SM_SEL_W-1:0] = sm_sel[off_sm[5:0]];
    else if (hit_mc)
      next_prdata = mc_cfg[off_mc[1:0]];
    else if (hit_st)
      next_prdata[4*NUM_MC+NUM_DED-1:0] = {q, o_buried_feedback, io_s, o_io_pin_out, ded_s};
    else if (hit_pt)
    begin
      case (off_pt[1:0])
        2'h0: next_prdata = pt_true[off_pt[6:2]][31:0];
        2'h1: next_prdata[PT_IN_W-33:0] = pt_true[off_pt[6:2]][PT_IN_W-1:32];
        2'h2: next_prdata = pt_comp[off_pt[6:2]][31:0];
        default: next_prdata[PT_IN_W-33:0] = pt_comp[off_pt[6:2]][PT_IN_W-1:32];
      endcase
    end
  end

  // Ready in the first access cycle; no wait states
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end
    else if (i_ce)
    begin
      if (i_psel && !i_penable && !o_pready)
      begin
        o_pready <= 1'b1;
        // Refused transfers answer with zero data, never a status snapshot
        if (hit_sm | hit_pt | hit_mc | (hit_st & ~i_pwrite))
          o_prdata <= next_prdata;
        else
          o_prdata <= '0;
        o_pslverr <= ~(hit_sm | hit_pt | hit_mc | (hit_st & ~i_pwrite));
      end
      else
      begin
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/cml_logic_block_monitor.sv
// Checker for the bus answer and pin enables of the macrocell slice
`timescale 1ns/1ps
`default_nettype none
module cml_logic_block_monitor
  import cml_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [cml_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pins
  input wire logic [cml_pkg::NUM_MC-1:0] o_io_pin_oe_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // --------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------
  // Setup phase seen by the slave; gated by freeze as the slave is
  logic setup;
  assign setup = i_psel && !i_penable && !o_pready && i_ce;

  a_ready_after_setup: assert property (setup |=> o_pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (o_pready && i_ce |=> !o_pready)
    else $error("pready longer than one cycle");
  a_ready_needs_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  a_idle_no_ready: assert property (!i_psel |=> !o_pready)
    else $error("pready without select");
  a_err_with_ready: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
    else $error("slverr without pready or with data");
  a_bad_addr_err: assert property (setup && (i_paddr[1:0] != 2'b00 || i_paddr >= 12'h400) |=> o_pslverr)
    else $error("unmapped access not refused");
  a_status_write_err: assert property (setup && i_pwrite && i_paddr == STAT_ADDR |=> o_pslverr)
    else $error("status write not refused");
  a_cfg_access_ok: assert property (setup && i_paddr == MC_BASE |=> !o_pslverr)
    else $error("config access refused");
  a_prdata_holds: assert property (!o_pready |-> $stable(o_prdata))
    else $error("read data moved between answers");
  a_oe_after_reset: assert property ($rose(i_rst_n) |-> o_io_pin_oe_n == 4'hf)
    else $error("pins driven after reset");

  // Main scenarios reached
  c_cfg_write: cover property (setup && i_pwrite && i_paddr == MC_BASE);
  c_refused: cover property (o_pslverr);
  c_pin_driven: cover property (o_io_pin_oe_n[0] == 1'b0);
endmodule

bind cml_logic_block cml_logic_block_monitor cml_logic_block_monitor_i (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_ce(i_ce),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_io_pin_oe_n(o_io_pin_oe_n)
);
`default_nettype wire

// file: dv/cml_logic_block_tb.sv
// Self-checking testbench for the macrocell logic block slice
`timescale 1ns/1ps
`default_nettype none
module cml_logic_block_tb;
  import cml_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ded = 4'h0;
  logic [3:0] io_in = 4'h0;
  logic [3:0] io_out;
  logic [3:0] oe_n;
  logic [55:0] ext = '0;
  logic [3:0] fb;
  logic cin = 1'b0;
  logic cout;
  logic [31:0] rdat;
  logic rerr;
  int n_errors = 0;
  int checks = 0;

  // Ordinary combinational cases: config word, sum input, pin value
  typedef struct {logic [31:0] cfg; logic x; logic exp;} cml_row_t;
  cml_row_t rows [5] = '{
    '{32'h0480_0081, 1'b1, 1'b1},
    '{32'h0480_0081, 1'b0, 1'b0},
    '{32'h0480_0041, 1'b1, 1'b0},
    '{32'h0480_0040, 1'b0, 1'b1},
    '{32'h0480_0001, 1'b1, 1'b0}};

  always #10 clk = ~clk;

  cml_logic_block cml_logic_block_i (
    .i_clk(clk),
    .i_rst_n(rst_n),
    .i_ce(ce),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_dedicated_pins(ded),
    .i_io_pin_in(io_in),
    .o_io_pin_out(io_out),
    .o_io_pin_oe_n(oe_n),
    .i_global_bus_ext(ext),
    .o_buried_feedback(fb),
    .i_cascade_sum_input(cin),
    .o_cascade_sum_output(cout)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Pins pass two sync flops, so let the slice settle
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  // A full rising and falling edge on global clock pin 0
  task automatic pulse;
    ded[0] <= 1'b1;
    settle();
    ded[0] <= 1'b0;
    settle();
  endtask

  task automatic report_and_stop;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #400_000;
    n_errors++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(oe_n, 4'hf);
    chk(io_out, 4'h0);
    apb(1'b0, MC_BASE, 32'h0);
    chk(rdat, MC_CFG_RST);
    apb(1'b0, 12'h400, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, STAT_ADDR, 32'h0000_FFFF);
    chk(rerr, 1'b1);
    $display("reset and map test done");
    // Matrix inputs 0 and 1 take external bus bits 0 and 1
    apb(1'b1, SM_BASE, 32'h0000_000C);
    apb(1'b1, SM_BASE + 12'h004, 32'h0000_000D);
    apb(1'b1, PT_BASE, 32'h0000_0001);
    apb(1'b1, PT_BASE + 12'h020, 32'h0000_0002);
    foreach (rows[i])
    begin
      apb(1'b1, MC_BASE, rows[i].cfg);
      ext[0] <= rows[i].x;
      settle();
      chk(io_out[0], rows[i].exp);
      chk(fb[0], rows[i].exp);
      chk(oe_n[0], 1'b0);
      $display("row %0d done", i);
    end
    // Registered D: change only on rising edge of the chosen clock
    apb(1'b1, MC_BASE, 32'h0488_0081);
    ext[0] <= 1'b1;
    settle();
    chk(io_out[0], 1'b0);
    pulse();
    chk(io_out[0], 1'b1);
    ext[0] <= 1'b0;
    settle();
    chk(io_out[0], 1'b1);
    pulse();
    chk(io_out[0], 1'b0);
    $display("registered test done");
    // Clock enable from the second matrix input
    apb(1'b1, MC_BASE, 32'h0488_8081);
    ext[0] <= 1'b1;
    pulse();
    chk(io_out[0], 1'b0);
    ext[1] <= 1'b1;
    pulse();
    chk(io_out[0], 1'b1);
    // Toggle mode with a steady high input
    apb(1'b1, MC_BASE, 32'h0488_0481);
    pulse();
    chk(io_out[0], 1'b0);
    pulse();
    chk(io_out[0], 1'b1);
    $display("enable and toggle test done");
    // Preset from an all-open term, clear from a dedicated pin
    apb(1'b1, MC_BASE, 32'h048D_0081);
    ext[0] <= 1'b0;
    settle();
    chk(io_out[0], 1'b1);
    ded[3] <= 1'b1;
    settle();
    chk(io_out[0], 1'b0);
    ded[3] <= 1'b0;
    settle();
    chk(io_out[0], 1'b1);
    // Latch: pass while clock high, hold while low
    apb(1'b1, MC_BASE, 32'h0488_1081);
    ded[0] <= 1'b1;
    settle();
    chk(io_out[0], 1'b0);
    ext[0] <= 1'b1;
    settle();
    chk(io_out[0], 1'b1);
    ded[0] <= 1'b0;
    settle();
    ext[0] <= 1'b0;
    settle();
    chk(io_out[0], 1'b1);
    $display("clear and latch test done");
    // Combinational output beside registered feedback
    apb(1'b1, MC_BASE, 32'h0490_0081);
    settle();
    chk({io_out[0], fb[0]}, 2'b01);
    pulse();
    chk(fb[0], 1'b0);
    // Output enable from dedicated pin 2, true then complement
    apb(1'b1, MC_BASE, 32'h0800_0081);
    ded[2] <= 1'b1;
    settle();
    chk(oe_n[0], 1'b0);
    ded[2] <= 1'b0;
    settle();
    chk(oe_n[0], 1'b1);
    apb(1'b1, MC_BASE, 32'h0820_0081);
    settle();
    chk(oe_n[0], 1'b0);
    $display("feedback and enable test done");
    // Cascade: macrocells 1 to 3 pass the chain on, macrocell 0 adds its term
    for (int m = 1; m < NUM_MC; m++)
      apb(1'b1, MC_BASE + 12'(4 * m), 32'h0000_0020);
    ext[0] <= 1'b1;
    settle();
    chk(cout, 1'b1);
    apb(1'b1, MC_BASE, 32'h0000_0020);
    ext[0] <= 1'b0;
    settle();
    chk(cout, 1'b0);
    cin <= 1'b1;
    settle();
    chk(cout, 1'b1);
    // Flop data straight from the pin
    apb(1'b1, MC_BASE, 32'h0008_0200);
    io_in[0] <= 1'b1;
    pulse();
    chk(io_out[0], 1'b1);
    $display("cascade and pin data test done");
    // Reset in mid-run clears config and outputs
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({cout, oe_n}, 5'h0f);
    apb(1'b0, MC_BASE + 12'h004, 32'h0);
    chk(rdat, MC_CFG_RST);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
